// [core/pcs_port.sv]
// PCM serial port of a voice-band codec: frame timing, shifters, standby,
// output floating and an Avalon-MM control slave.
// Assumes link pins arrive asynchronously and are oversampled by clk_sys.
`timescale 1ns/10ps
`default_nettype none

// Contract
// RULE1: Words are 8 companded, 16 linear bits
// RULE2: Most significant bit travels first
// RULE3: Outputs float about four frames after power-up
// RULE4: Master clock loss floats both outputs
// RULE5: Power-down low floats outputs regardless
// RULE6: Both syncs low gives full standby, floated
// RULE7: Transmit sync low floats outputs within frames
// RULE8: Receive sync low keeps outputs active
// RULE9: Receive bit clock high selects fixed timing
// RULE10: Fixed timing launches on master clock rise
// RULE11: Fixed timing samples on master clock fall
// RULE12: Receive bit clock activity selects variable timing
// RULE13: Host keeps bit clocks synchronous, not faster
// RULE14: Variable transmit shifts on bit clock rise
// RULE15: Variable receive captures on bit clock fall
// RULE16: Variable timing repeats word while sync high
// RULE17: Host aligns clocks and strobe each frame
// RULE18: Linear samples are 13-bit two's complement
// RULE19: Companded squelch sends zeros with hysteresis
// RULE20: Microphone mute forces all-zero transmit words
// RULE21: Host starts clocks, then power, then syncs
// RULE22: Strobe spans bit one to last bit
// RULE23: Linear tail: volume in, zero pad out
// RULE24: Three volume bits select attenuation step
// RULE25: Companded receive: first eight fixed, last eight variable
module pcs_port
   import pcs_pkg::*;
#(
   parameter int unsigned PWRUP_CYCLES = PWRUP_CYC,  // Power-up hold-off in cycles
   parameter int unsigned IDLE_CYCLES  = IDLE_CYC,   // Sync silence taken as standby
   parameter logic [11:0] SQ_ON_LVL    = SQ_ON_DEF,  // Squelch entry level
   parameter logic [11:0] SQ_OFF_LVL   = SQ_OFF_DEF  // Squelch exit level
)(
   input  wire logic         clk_sys,          // System clock, 40 MHz
   input  wire logic         rst_b,            // Synchronous reset, active low
   input  wire pcs_pins_t    pins_in,          // Raw link pins
   input  wire logic [15:0]  tx_sample,        // Encoder word, left aligned
   input  wire logic [11:0]  tx_level,         // Encoder input magnitude
   input  wire logic [3:0]   avs_address,      // Avalon byte address
   input  wire logic         avs_read,         // Avalon read
   input  wire logic         avs_write,        // Avalon write
   input  wire logic [31:0]  avs_writedata,    // Avalon write data
   output logic [31:0]       avs_readdata,     // Avalon read data
   output logic              avs_waitrequest,  // Avalon wait
   output pcs_tx_pins_t      tx_pins,          // Transmit data and strobe pins
   output logic [15:0]       rx_word,          // Received word, left aligned
   output logic [2:0]        rx_attn,          // Attenuation step, 3 dB each
   output logic              rx_valid,         // One-cycle receive pulse
   output logic              tx_standby,       // Transmit channel idle
   output logic              rx_standby        // Receive channel idle
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   pcs_pins_t          pin1_ff, pin2_ff, pin3_ff;  // Synchroniser and edge stages
   logic [3:0]         ev;                        // Activity events per watch
   logic [3:0]         quiet_ff;                  // Watch timed out
   logic [CNT_W-1:0]   pwr_cnt_ff;                // Power-up hold-off count
   logic               pwr_ok_ff;                 // Hold-off elapsed
   logic               var_ff;                    // Variable timing selected
   logic               sq_ff;                     // Squelch active
   logic [CTRL_W-1:0]  ctrl_ff;                   // Control register
   pcs_tx_st_t         tx_st_ff;                  // Transmit state
   logic [15:0]        tx_sh_ff, tx_word_ff;      // Shifter and repeat copy
   logic [4:0]         tx_idx_ff;                 // Transmit bit index
   logic               tx_arm_ff;                 // Frame sync seen, fixed
   pcs_rx_st_t         rx_st_ff;                  // Receive state
   logic [15:0]        rx_sh_ff;                  // Receive shifter
   logic [4:0]         rx_idx_ff;                 // Receive bit index, fixed
   pcs_tx_pins_t       tx_pins_ff;                // Registered pin outputs
   logic [15:0]        rx_word_ff;                // Held word
   logic [2:0]         rx_attn_ff;                // Held attenuation
   logic               rx_valid_ff, tx_stb_ff, rx_stb_ff;
   logic [31:0]        rdata_ff, nxt_rdata;       // Bus read path
   logic               wait_ff;                   // Bus wait state
   logic               linear, mute, out_ok, drive, tx_start;
   logic [4:0]         len_m1;                    // Word length less one
   logic [15:0]        nxt_tx_word;
   logic mclk_r, mclk_f, fsx_r, fsr_r, fsr_f, txb_r, rxb_f;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Stage 1 feeds only stage 2; edges compare stages 2 and 3
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pin1_ff <= '{rx_bclk: 1'b1, default: 1'b0};  // Bit clock idles high, so a
         pin2_ff <= '{rx_bclk: 1'b1, default: 1'b0};  // tied-high pin shows no false
         pin3_ff <= '{rx_bclk: 1'b1, default: 1'b0};  // edge and fixed timing holds
      end else begin
         pin1_ff <= pins_in;
         pin2_ff <= pin1_ff;
         pin3_ff <= pin2_ff;
      end
   end

   assign mclk_r = pin2_ff.mclk & ~pin3_ff.mclk;
   assign mclk_f = ~pin2_ff.mclk & pin3_ff.mclk;
   assign fsx_r  = pin2_ff.tx_fs & ~pin3_ff.tx_fs;
   assign fsr_r  = pin2_ff.rx_fs & ~pin3_ff.rx_fs;
   assign fsr_f  = ~pin2_ff.rx_fs & pin3_ff.rx_fs;
   assign txb_r  = pin2_ff.tx_bclk & ~pin3_ff.tx_bclk;
   assign rxb_f  = ~pin2_ff.rx_bclk & pin3_ff.rx_bclk;

   // Watch events: master clock, both syncs, receive bit clock
   assign ev = {pin2_ff.rx_bclk ^ pin3_ff.rx_bclk, fsr_r, fsx_r, mclk_r | mclk_f};

   // ----------------------------------------------------------------
   // Activity watches
   // ----------------------------------------------------------------
   // Master clock uses a short limit; syncs and bit clock one of frames
   for (genvar i = 0; i < 4; i++) begin : g_watch
      localparam logic [CNT_W-1:0] LIM = (i == 0) ? CNT_W'(LOSS_CYC) : CNT_W'(IDLE_CYCLES);
      logic [CNT_W-1:0] cnt_ff;  // Cycles since last event
      always_ff @(posedge clk_sys) begin
         if (!rst_b) begin
            cnt_ff      <= '0;
            quiet_ff[i] <= 1'b1;
         end else if (ev[i]) begin
            cnt_ff      <= '0;
            quiet_ff[i] <= 1'b0;
         end else if (cnt_ff >= LIM) begin
            quiet_ff[i] <= 1'b1;     // RULE4 RULE6 RULE7
         end else begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

   // Timing mode: a receive bit clock that toggles selects variable rate
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         var_ff <= 1'b0;
      end else if (ev[3]) begin
         var_ff <= 1'b1;                                   // RULE12
      end else if (quiet_ff[3] && pin2_ff.rx_bclk) begin
         var_ff <= 1'b0;                                   // RULE9
      end
   end

   // ----------------------------------------------------------------
   // Power-up hold-off
   // ----------------------------------------------------------------
   // Restarts on power-down or lost master clock, so outputs come back late
   always_ff @(posedge clk_sys) begin
      if (!rst_b || !pin2_ff.pdn_n || quiet_ff[0]) begin
         pwr_cnt_ff <= '0;
         pwr_ok_ff  <= 1'b0;
      end else if (pwr_cnt_ff >= CNT_W'(PWRUP_CYCLES)) begin
         pwr_ok_ff  <= 1'b1;                               // RULE3
      end else begin
         pwr_cnt_ff <= pwr_cnt_ff + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Squelch with hysteresis
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sq_ff <= 1'b0;
      end else if (tx_level < SQ_ON_LVL) begin
         sq_ff <= 1'b1;                                    // RULE19
      end else if (tx_level > SQ_OFF_LVL) begin
         sq_ff <= 1'b0;                                    // RULE19
      end
   end

   // ----------------------------------------------------------------
   // Transmit word and gating
   // ----------------------------------------------------------------
   assign linear = ctrl_ff[CTRL_LIN];
   assign mute   = pin2_ff.mute | ctrl_ff[CTRL_MUTE];
   assign len_m1 = linear ? LEN_LIN - 5'h01 : LEN_COMP - 5'h01;   // RULE1
   // Outputs live only when powered, settled, clocked and framed
   assign out_ok = pin2_ff.pdn_n & pwr_ok_ff & ~quiet_ff[0] & ~quiet_ff[1];  // RULE5 RULE8
   assign drive  = (tx_st_ff == TX_SHIFT) & out_ok;

   always_comb begin
      if (mute || (!linear && sq_ff)) begin
         nxt_tx_word = '0;                                 // RULE19 RULE20
      end else if (linear) begin
         nxt_tx_word = {tx_sample[15:16-LIN_BITS], VOL_BITS'(0)};  // RULE18 RULE23
      end else begin
         nxt_tx_word = {tx_sample[15:8], 8'h00};           // RULE1
      end
   end

   // Fixed: first master rise after sync; variable: sync rise itself
   assign tx_start = (tx_st_ff == TX_IDLE) && pin2_ff.pdn_n &&
                     (var_ff ? fsx_r : (tx_arm_ff && pin2_ff.tx_fs && mclk_r));  // RULE10 RULE14

   // ----------------------------------------------------------------
   // Transmit shifter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         tx_st_ff   <= TX_IDLE;
         tx_sh_ff   <= '0;
         tx_word_ff <= '0;
         tx_idx_ff  <= '0;
         tx_arm_ff  <= 1'b0;
      end else begin
         if (fsx_r) begin
            tx_arm_ff <= 1'b1;
         end
         unique case (tx_st_ff)
            TX_IDLE: begin
               if (tx_start) begin
                  tx_sh_ff   <= nxt_tx_word;               // RULE2
                  tx_word_ff <= nxt_tx_word;
                  tx_idx_ff  <= '0;
                  tx_arm_ff  <= 1'b0;
                  tx_st_ff   <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (!pin2_ff.pdn_n) begin
                  tx_st_ff <= TX_IDLE;
               end else if (!var_ff) begin
                  if (mclk_r && tx_idx_ff != len_m1) begin
                     tx_sh_ff  <= {tx_sh_ff[14:0], 1'b0};  // RULE10
                     tx_idx_ff <= tx_idx_ff + 5'h01;
                  end else if (mclk_f && tx_idx_ff == len_m1) begin
                     tx_st_ff <= TX_IDLE;                  // RULE22
                  end
               end else if (!pin2_ff.tx_fs) begin
                  tx_st_ff <= TX_IDLE;
               end else if (txb_r) begin
                  if (tx_idx_ff == len_m1) begin
                     tx_sh_ff  <= tx_word_ff;              // RULE16
                     tx_idx_ff <= '0;
                  end else begin
                     tx_sh_ff  <= {tx_sh_ff[14:0], 1'b0};  // RULE14
                     tx_idx_ff <= tx_idx_ff + 5'h01;
                  end
               end
            end
         endcase
      end
   end

   // Pins: strobe only exists in fixed timing, open drain pulled low
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         tx_pins_ff <= '{data: 1'b0, data_oe_n: 1'b1, strobe_n: 1'b1, strobe_oe_n: 1'b1};
      end else begin
         tx_pins_ff.data        <= tx_sh_ff[15];               // RULE2
         tx_pins_ff.data_oe_n   <= ~drive;                     // RULE3 RULE4 RULE5 RULE6 RULE7
         tx_pins_ff.strobe_n    <= ~(drive & ~var_ff);         // RULE22
         tx_pins_ff.strobe_oe_n <= ~(drive & ~var_ff);         // RULE22
      end
   end

   // ----------------------------------------------------------------
   // Receive shifter
   // ----------------------------------------------------------------
   // Companded word is the low byte either way: fixed stops after eight,
   // variable keeps shifting so the low byte holds the last eight
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rx_st_ff  <= RX_IDLE;
         rx_sh_ff  <= '0;
         rx_idx_ff <= '0;
      end else begin
         unique case (rx_st_ff)
            RX_IDLE: begin
               if (fsr_r && pin2_ff.pdn_n) begin
                  rx_idx_ff <= '0;
                  rx_st_ff  <= RX_SHIFT;
               end
            end
            RX_SHIFT: begin
               if (!var_ff) begin
                  if (mclk_f) begin
                     rx_sh_ff  <= {rx_sh_ff[14:0], pin2_ff.rx_data};  // RULE11 RULE2
                     rx_idx_ff <= rx_idx_ff + 5'h01;
                     if (rx_idx_ff == len_m1) begin
                        rx_st_ff <= RX_DONE;                          // RULE25
                     end
                  end
               end else if (fsr_f) begin
                  rx_st_ff <= RX_DONE;                                // RULE25
               end else if (rxb_f && pin2_ff.rx_fs) begin
                  rx_sh_ff <= {rx_sh_ff[14:0], pin2_ff.rx_data};     // RULE15
               end
            end
            RX_DONE: begin
               rx_st_ff <= RX_IDLE;
            end
            default: begin
               rx_st_ff <= RX_IDLE;
            end
         endcase
      end
   end

   // Word and volume unpack; volume is not held across words
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rx_word_ff  <= '0;
         rx_attn_ff  <= '0;
         rx_valid_ff <= 1'b0;
         tx_stb_ff   <= 1'b0;
         rx_stb_ff   <= 1'b0;
      end else begin
         rx_valid_ff <= (rx_st_ff == RX_DONE);
         tx_stb_ff   <= quiet_ff[1] & pin2_ff.pdn_n;                 // RULE7
         rx_stb_ff   <= quiet_ff[2] & pin2_ff.pdn_n;                 // RULE8
         if (rx_st_ff == RX_DONE) begin
            if (linear) begin
               rx_word_ff <= {rx_sh_ff[15:VOL_BITS], VOL_BITS'(0)};  // RULE18 RULE23
               rx_attn_ff <= rx_sh_ff[VOL_BITS-1:0];                 // RULE24
            end else begin
               rx_word_ff <= {rx_sh_ff[7:0], 8'h00};                 // RULE1
               rx_attn_ff <= '0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------
   // Unmapped addresses read zero and ignore writes
   always_comb begin
      nxt_rdata = '0;
      unique case (avs_address)
         A_CTRL:  nxt_rdata[CTRL_W-1:0] = ctrl_ff;
         A_STAT:  nxt_rdata[6:0] = {var_ff, sq_ff, rx_stb_ff, tx_stb_ff,
                                    ~pin2_ff.pdn_n, quiet_ff[0], pwr_ok_ff};
         A_RXW:   nxt_rdata[18:0] = {rx_attn_ff, rx_word_ff};
         default: nxt_rdata = '0;
      endcase
   end

   // One wait cycle per access; the request completes on the next edge
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wait_ff  <= 1'b1;
         rdata_ff <= '0;
         ctrl_ff  <= '0;
      end else begin
         wait_ff <= ~((avs_read | avs_write) & wait_ff);
         if (avs_read && wait_ff) begin
            rdata_ff <= nxt_rdata;
         end
         if (avs_write && !wait_ff && avs_address == A_CTRL) begin
            ctrl_ff <= avs_writedata[CTRL_W-1:0];
         end
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign tx_pins         = tx_pins_ff;
   assign rx_word         = rx_word_ff;
   assign rx_attn         = rx_attn_ff;
   assign rx_valid        = rx_valid_ff;
   assign tx_standby      = tx_stb_ff;
   assign rx_standby      = rx_stb_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_load;
      tx_start ##1 (tx_st_ff == TX_SHIFT);
   endsequence

   a_pdn_float: assert property (!pin2_ff.pdn_n |=> tx_pins_ff.data_oe_n && tx_pins_ff.strobe_oe_n) // RULE5
      else $error("outputs driven in power-down");
   a_mclk_float: assert property (quiet_ff[0] |=> tx_pins_ff.data_oe_n) // RULE4
      else $error("output driven without master clock");
   a_pwrup_hold: assert property (!pwr_ok_ff |=> tx_pins_ff.data_oe_n && tx_pins_ff.strobe_oe_n) // RULE3
      else $error("output driven during hold-off");
   a_idle_float: assert property (quiet_ff[1] |=> tx_pins_ff.data_oe_n) // RULE7
      else $error("output driven with idle transmit sync");
   a_rx_idle_live: assert property ((quiet_ff[2] && out_ok && tx_st_ff == TX_SHIFT) |=> !tx_pins_ff.data_oe_n) // RULE8
      else $error("receive standby floated output");
   a_mute_zero: assert property ((tx_start && mute) |=> tx_sh_ff == 16'h0000) // RULE20
      else $error("mute word not zero");
   a_msb_first: assert property (s_load |-> ##1 tx_pins_ff.data == tx_word_ff[15]) // RULE2
      else $error("first bit not msb");
   a_var_repeat: assert property ((var_ff && tx_st_ff == TX_SHIFT && pin2_ff.pdn_n && pin2_ff.tx_fs && txb_r
                                   && tx_idx_ff == len_m1) |=> tx_idx_ff == 5'h00 && tx_sh_ff == tx_word_ff) // RULE16
      else $error("word not repeated");
   a_strobe_fixed: assert property (!tx_pins_ff.strobe_n |-> !$past(var_ff) && $past(tx_st_ff == TX_SHIFT)) // RULE22
      else $error("strobe outside fixed slot");
   a_comp_len: assert property ((rx_valid_ff && !linear) |-> rx_word_ff[7:0] == 8'h00 && rx_attn_ff == 3'h0) // RULE1
      else $error("companded word too wide");
   a_lin_pad: assert property ((tx_start && linear) |=> tx_sh_ff[2:0] == 3'h0) // RULE23
      else $error("linear pad not zero");

endmodule

`default_nettype wire

// [core/pcs_pkg.sv]
// Constants, carrier structs and state codes of the PCM serial port.
// Assumes a 40 MHz system clock; all link pins are asynchronous to it.
package pcs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_NS    = 25;                                   // System clock period
   localparam int unsigned PWRUP_US  = 500;                                  // Output hold-off after power-up
   localparam int unsigned PWRUP_CYC = (PWRUP_US * 1000 + CLK_NS - 1) / CLK_NS; // Least time, rounded up
   localparam int unsigned FRAME_US  = 125;                                  // One frame at 8 kHz
   localparam int unsigned IDLE_FRM  = 2;                                    // Frames without sync = idle
   localparam int unsigned IDLE_CYC  = (IDLE_FRM * FRAME_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned LOSS_NS   = 1000;                                 // Master clock silence = lost
   localparam int unsigned LOSS_CYC  = LOSS_NS / CLK_NS;                     // Longest time, rounded down
   localparam int unsigned CNT_W     = 16;                                   // Watch counter width

   // ----------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------
   localparam logic [4:0]  LEN_COMP  = 5'h08;    // Companded word length
   localparam logic [4:0]  LEN_LIN   = 5'h10;    // Linear word length
   localparam int unsigned LIN_BITS  = 13;       // Two's complement sample bits
   localparam int unsigned VOL_BITS  = 3;        // Attenuation bits trailing a linear word
   localparam logic [11:0] SQ_ON_DEF  = 12'h010; // Squelch entry level
   localparam logic [11:0] SQ_OFF_DEF = 12'h020; // Squelch exit level, above entry

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] A_CTRL = 4'h0;         // Control, read/write
   localparam logic [3:0] A_STAT = 4'h4;         // Status, read only
   localparam logic [3:0] A_RXW  = 4'h8;         // Last received word, read only
   localparam int unsigned CTRL_LIN  = 0;        // Linear mode select
   localparam int unsigned CTRL_MUTE = 1;        // Software transmit mute
   localparam int unsigned CTRL_W    = 2;        // Control width

   // ----------------------------------------------------------------
   // Carriers and states
   // ----------------------------------------------------------------
   typedef struct packed {
      logic mclk;      // Master clock
      logic tx_fs;     // tx_frame_sync
      logic rx_fs;     // rx_frame_sync
      logic tx_bclk;   // tx_bit_clock
      logic rx_bclk;   // rx_bit_clock
      logic rx_data;   // Serial receive data
      logic pdn_n;     // power_down_n
      logic mute;      // microphone_silence_in
   } pcs_pins_t;

   typedef struct packed {
      logic data;      // Serial transmit data
      logic data_oe_n; // Low while data is driven
      logic strobe_n;  // tx_slot_strobe_n level
      logic strobe_oe_n; // Low while strobe is driven
   } pcs_tx_pins_t;

   typedef enum logic       {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} pcs_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_SHIFT = 2'b01, RX_DONE = 2'b11} pcs_rx_st_t;

endpackage

// [bench/pcs_host.sv]
// Host model: master clock, frame syncs and serial receive data.
// Assumes fixed timing unless vmode is set, when bit clocks follow the master clock.
`timescale 1ns/10ps
`default_nettype none
module pcs_host
   import pcs_pkg::*;
(
   output var pcs_pins_t    pins, // Pins into the port
   input  wire pcs_tx_pins_t tx   // Transmit pins out of it
);
   bit run = 1'b1; // Master clock enable
   initial pins = 8'h0A; // Fixed timing, powered up
   // 200 ns master clock, stops dead when disabled
   always #100 if (run) pins.mclk = !pins.mclk;
   bit vmode = 1'b0; // Bit clocks running
   // Bit clocks copy the master clock: synchronous, never faster
   always @(pins.mclk) if (vmode) begin
      pins.tx_bclk = pins.mclk;
      pins.rx_bclk = pins.mclk;
   end
   // Variable frame: syncs high for m bit clocks, data MSB first
   task automatic vframe(input logic [15:0] w, input int m, output logic [15:0] q);
      q = 16'h0000;
      @(posedge pins.mclk) #10;
      pins.tx_fs = 1'b1;
      pins.rx_fs = 1'b1;
      for (int i = 0; i < m; i++) begin
         pins.rx_data = w[15 - i];
         @(negedge pins.mclk) #50;
         q[15 - i] = (tx.data_oe_n === 1'b0) ? tx.data : 1'bx;
         @(posedge pins.mclk) #10;
      end
      pins.tx_fs = 1'b0;
      pins.rx_fs = 1'b0;
   endtask
   // One frame: syncs rise after a clock rise, bits move MSB first
   task automatic frame(input logic [15:0] w, input int n, output logic [15:0] q);
      q = 16'h0000;
      @(posedge pins.mclk) #10;
      pins.tx_fs = 1'b1;
      pins.rx_fs = 1'b1;
      for (int i = 0; i <= n; i++) begin
         if (i < n) pins.rx_data = w[15 - i];
         @(negedge pins.mclk) #50;
         if (i > 0) q[16 - i] = (tx.data_oe_n === 1'b0 && tx.strobe_n === 1'b0) ? tx.data : 1'bx;
         @(posedge pins.mclk) #10;
      end
      pins.tx_fs = 1'b0;
      pins.rx_fs = 1'b0;
      pins.rx_data = !pins.rx_data; // Released line shows no stale bit
   endtask
endmodule
`default_nettype wire

// [bench/pcs_port_tb.sv]
// Testbench of the PCM serial port: register bus, framed words, standby.
// Assumes the host model drives every link pin.
`timescale 1ns/10ps
`default_nettype none
module pcs_port_tb
   import pcs_pkg::*;
;
   logic clk_sys, rst_b, rd_en, wr_en, wait_r, rx_valid, tx_sb, rx_sb, sq;
   logic [3:0] adr;
   logic [31:0] wd, rd, q;
   logic [15:0] smp, rxw, got;
   logic [11:0] lvl;
   logic [2:0] attn;
   pcs_pins_t pins;
   pcs_tx_pins_t txp;
   int miscompares, check_count, cyc;
   pcs_port #(.PWRUP_CYCLES(50), .IDLE_CYCLES(4000)) pcs_port_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .pins_in(pins), .tx_sample(smp), .tx_level(lvl), .avs_address(adr), .avs_read(rd_en),
      .avs_write(wr_en), .avs_writedata(wd), .avs_readdata(rd), .avs_waitrequest(wait_r), .tx_pins(txp),
      .rx_word(rxw), .rx_attn(attn), .rx_valid(rx_valid), .tx_standby(tx_sb), .rx_standby(rx_sb));
   pcs_host pcs_host_inst (.pins(pins), .tx(txp));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = !clk_sys;
   end
   // Hang guard, well above the expected run
   always @(posedge clk_sys) if (++cyc == 12000) begin
      miscompares++;
      test_done;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Avalon access: request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys);
      adr <= a;
      wr_en <= w;
      rd_en <= !w;
      wd <= d;
      do @(posedge clk_sys); while (wait_r !== 1'b0);
      r = rd;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic t_regs;
      bus(1'b1, A_CTRL, 32'h0000_0003, q);
      bus(1'b0, A_CTRL, 32'h0, q);
      chk(q, 32'h0000_0003);
      bus(1'b0, 4'hC, 32'h0, q);
      chk(q, 32'h0);
      $display("registers done");
   endtask
   // Companded with squelch and hysteresis, then linear with mute pin
   task automatic t_words;
      logic [11:0] lv[6] = '{12'h100, 12'h008, 12'h018, 12'h100, 12'h008, 12'h100};
      logic [15:0] w, ex;
      bit lin;
      sq = 1'b0;
      for (int k = 0; k < 6; k++) begin
         lin = k > 3;
         w = {4{k[3:0]}} ^ 16'hA5C3;
         smp <= ~w;
         lvl <= lv[k];
         pcs_host_inst.pins.mute = (k == 5);
         bus(1'b1, A_CTRL, {31'h0, lin}, q);
         pcs_host_inst.frame(w, lin ? 16 : 8, got);
         if (lv[k] < SQ_ON_DEF) sq = 1'b1;
         else if (lv[k] > SQ_OFF_DEF) sq = 1'b0;
         ex = (k == 5 || (!lin && sq)) ? 16'h0 : lin ? {~w[15:3], 3'b000} : {~w[15:8], 8'h00};
         chk(32'(got), 32'(ex));
         chk(32'(rxw), lin ? 32'({w[15:3], 3'b000}) : 32'({w[15:8], 8'h00}));
         chk(32'(attn), lin ? 32'(w[2:0]) : 32'h0);
         chk(32'({txp.data_oe_n, txp.strobe_oe_n}), 32'h3);
      end
      $display("words done");
   endtask
   // Variable timing: word repeats while sync stays high, receive keeps last eight
   task automatic t_var;
      pcs_host_inst.pins.mute = 1'b0;
      pcs_host_inst.vmode = 1'b1;
      smp <= 16'h5A00;
      bus(1'b1, A_CTRL, 32'h0, q);
      pcs_host_inst.vframe(16'hC3E1, 16, got);
      chk(32'(got), 32'h5A5A);
      repeat (6) @(posedge clk_sys);
      chk(32'(rxw), 32'hE100);
      pcs_host_inst.vmode = 1'b0;
      pcs_host_inst.pins.rx_bclk = 1'b1;
      $display("variable done");
   endtask
   task automatic t_idle;
      repeat (4100) @(posedge clk_sys);
      chk(32'({tx_sb, rx_sb, txp.data_oe_n, txp.strobe_oe_n}), 32'hF);
      bus(1'b0, A_STAT, 32'h0, q);
      chk(q & 32'h1F, 32'h19);
      pcs_host_inst.pins.pdn_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      bus(1'b0, A_STAT, 32'h0, q);
      chk(q & 32'h1F, 32'h04);
      pcs_host_inst.run = 1'b0;
      repeat (60) @(posedge clk_sys);
      bus(1'b0, A_STAT, 32'h0, q);
      chk(q & 32'h02, 32'h02);
      $display("idle done");
   endtask
   initial begin
      rst_b = 1'b0;
      rd_en = 1'b0;
      wr_en = 1'b0;
      adr = 4'h0;
      wd = 32'h0;
      smp = 16'h0;
      lvl = 12'h100;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      chk(32'({txp.data_oe_n, txp.strobe_oe_n}), 32'h3);
      repeat (60) @(posedge clk_sys);
      t_regs;
      t_words;
      t_var;
      t_idle;
      test_done;
   end
endmodule
`default_nettype wire
